// ---- src/e1_rx_info_pkg.sv ----
// constants shared by the receive information and synchronizer status block
package e1_rx_info_pkg;
	// register offsets on the parallel control port
	localparam logic [7:0] FLAGS_OFFSET = 8'h08;
	localparam logic [7:0] STATUS_OFFSET = 8'h1e;
	// receive_information_flags bit positions
	localparam int TX_FULL_BIT = 7;
	localparam int TX_EMPTY_BIT = 6;
	localparam int JIT_LIMIT_BIT = 5;
	localparam int RX_FULL_BIT = 4;
	localparam int RX_EMPTY_BIT = 3;
	localparam int CRC_RESYNC_BIT = 2;
	localparam int FAS_RESYNC_BIT = 1;
	localparam int CAS_RESYNC_BIT = 0;
	// reset values
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] RDATA_RESET = 8'h00;
	localparam logic [5:0] SYNC_COUNT_RESET = 6'h00;
	// jitter attenuator trips this many bit positions short of its limit
	localparam int JIT_LIMIT_MARGIN_BITS = 4;
	// crc-4 resync window: 915 errored out of 1000 codewords
	localparam logic [9:0] CRC_WINDOW = 10'h03e8;
	localparam logic [9:0] CRC_ERR_LIMIT = 10'h0393;
	// consecutive errored alignment words for fas and cas resync
	localparam logic [1:0] FAS_ERR_RUN = 2'h3;
	localparam logic [1:0] CAS_ERR_RUN = 2'h2;
	// crc-4 multiframe search timeout, counted by the framer
	localparam int CRC_SEARCH_TIMEOUT_MS = 8;
	// index of each source in the synchroniser bank
	localparam int SRC_TX_FULL = 0;
	localparam int SRC_TX_EMPTY = 1;
	localparam int SRC_JIT_LIMIT = 2;
	localparam int SRC_RX_FULL = 3;
	localparam int SRC_RX_EMPTY = 4;
	localparam int SRC_CRC_WORD = 5;
	localparam int SRC_CRC_ERR = 6;
	localparam int SRC_FAS_WORD = 7;
	localparam int SRC_FAS_ERR = 8;
	localparam int SRC_CAS_WORD = 9;
	localparam int SRC_CAS_ERR = 10;
	localparam int SRC_CRC_TIMEOUT = 11;
	localparam int SRC_CRC_LOCKED = 12;
	localparam int SRC_CRC4_ENABLE = 13;
	localparam int SRC_FAS_SEARCH = 14;
	localparam int SRC_CAS_SEARCH = 15;
	localparam int SRC_CRC_SEARCH = 16;
	localparam int SRC_COUNT = 17;
endpackage

// ---- src/event_sync.sv ----
// two-flop synchroniser with change detection for one foreign-domain source
`timescale 1ns/1ps
module event_sync (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic async_in,
	output logic level,
	output logic change
);
	typedef struct packed {
		logic meta;
		logic stable;
		logic prev;
	} sync_state_t;

	sync_state_t st;
	sync_state_t next_st;

	// meta feeds only stable; edge logic looks at stable and prev
	always_comb begin
		next_st = st;
		next_st.meta = async_in;
		next_st.stable = st.meta;
		next_st.prev = st.stable;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign level = st.stable;
	assign change = st.stable ^ st.prev; // toggle sources give one pulse per event
endmodule // event_sync

// ---- src/e1_rx_info_sync_status.sv ----
// receive information flags and synchronizer live status registers
// How it works
// RL1 - tx slip buffer overflow sets bit 7
// RL2 - tx slip buffer underflow sets bit 6
// RL3 - jitter fifo near limit sets bit 5
// RL4 - rx slip buffer overflow sets bit 4
// RL5 - rx slip buffer underflow sets bit 3
// RL6 - 915 of 1000 crc words errored sets bit 2
// RL7 - three errored fas words set bit 1
// RL8 - fas re-search during crc resync sets bit 1
// RL9 - two errored cas words set bit 0
// RL10 - sync counter bits 5,4,3,2,0 in status 7..3
// RL11 - fas search active shown live in bit 2
// RL12 - cas search active shown live in bit 1
// RL13 - crc search active shown live in bit 0
// RL14 - flags latch until cleared by a mask write, set again on recurrence
// RL15 - mask write refreshes and clears only ones
// RL16 - status register is live, read-only, no mask
// RL17 - counter counts timeouts, clears on lock/disable, wraps
// RL18 - every source synchronised, flag events never lost; a timeout coincident with a counter clear is dropped
`timescale 1ns/1ps
module e1_rx_info_sync_status (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [7:0] addr,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	output logic rd_valid,
	input wire logic tx_slip_buffer_full,
	input wire logic tx_slip_buffer_empty,
	input wire logic jitter_fifo_limit_trip,
	input wire logic rx_slip_buffer_full,
	input wire logic rx_slip_buffer_empty,
	input wire logic crc_word_toggle,
	input wire logic crc_word_errored,
	input wire logic fas_word_toggle,
	input wire logic fas_word_errored,
	input wire logic cas_word_toggle,
	input wire logic cas_word_errored,
	input wire logic crc_search_timeout,
	input wire logic crc_sync_locked,
	input wire logic crc4_mode_enable,
	input wire logic frame_align_search_active,
	input wire logic signaling_mf_search_active,
	input wire logic crc_mf_search_active
);
	typedef struct packed {
		logic [7:0] flags;
		logic [7:0] snap;
		logic [7:0] rd_data;
		logic rd_valid;
		logic [9:0] word_cnt;
		logic [9:0] err_cnt;
		logic [1:0] fas_run;
		logic [1:0] cas_run;
		logic [5:0] sync_count;
		logic fas_search_prev;
	} info_state_t;

	info_state_t st;
	info_state_t next_st;
	logic [e1_rx_info_pkg::SRC_COUNT-1:0] raw;
	logic [e1_rx_info_pkg::SRC_COUNT-1:0] lvl;
	logic [e1_rx_info_pkg::SRC_COUNT-1:0] pulse;
	logic [7:0] live_status;

	// event sources toggle once per event; qualifiers are held stable around the toggle
	assign raw = {crc_mf_search_active, signaling_mf_search_active, frame_align_search_active,
		crc4_mode_enable, crc_sync_locked, crc_search_timeout, cas_word_errored, cas_word_toggle,
		fas_word_errored, fas_word_toggle, crc_word_errored, crc_word_toggle, rx_slip_buffer_empty,
		rx_slip_buffer_full, jitter_fifo_limit_trip, tx_slip_buffer_empty, tx_slip_buffer_full};

	// every foreign source crosses through its own two flops
	genvar gi;
	generate
		for (gi = 0; gi < e1_rx_info_pkg::SRC_COUNT; gi++) begin : g_sync
			event_sync u_sync ( // RL18
				.clk_sys(clk_sys),
				.rst_b(rst_b),
				.async_in(raw[gi]),
				.level(lvl[gi]),
				.change(pulse[gi])
			);
		end
	endgenerate

	// live view; counter bit 1 is deliberately not visible
	assign live_status = {st.sync_count[5:2], st.sync_count[0], // RL10
		lvl[e1_rx_info_pkg::SRC_FAS_SEARCH], // RL11
		lvl[e1_rx_info_pkg::SRC_CAS_SEARCH], // RL12
		lvl[e1_rx_info_pkg::SRC_CRC_SEARCH]}; // RL13

	// one address compare shared by the mask write and the read mux
	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] offset);
		return a == offset;
	endfunction

	// all register and detector updates
	always_comb begin
		logic [7:0] ev;
		ev = 8'h00;
		next_st = st;
		next_st.rd_valid = 1'b0;
		// slip buffer and jitter events; margin judged inside the attenuator
		ev[e1_rx_info_pkg::TX_FULL_BIT] = pulse[e1_rx_info_pkg::SRC_TX_FULL]; // RL1
		ev[e1_rx_info_pkg::TX_EMPTY_BIT] = pulse[e1_rx_info_pkg::SRC_TX_EMPTY]; // RL2
		ev[e1_rx_info_pkg::JIT_LIMIT_BIT] = pulse[e1_rx_info_pkg::SRC_JIT_LIMIT]; // RL3
		ev[e1_rx_info_pkg::RX_FULL_BIT] = pulse[e1_rx_info_pkg::SRC_RX_FULL]; // RL4
		ev[e1_rx_info_pkg::RX_EMPTY_BIT] = pulse[e1_rx_info_pkg::SRC_RX_EMPTY]; // RL5
		// crc-4 window: fixed blocks of 1000 words, flag once when errors reach 915
		if (pulse[e1_rx_info_pkg::SRC_CRC_WORD]) begin
			if (lvl[e1_rx_info_pkg::SRC_CRC_ERR] && st.err_cnt == e1_rx_info_pkg::CRC_ERR_LIMIT - 10'h001) begin
				ev[e1_rx_info_pkg::CRC_RESYNC_BIT] = 1'b1; // RL6
			end
			if (st.word_cnt == e1_rx_info_pkg::CRC_WINDOW - 10'h001) begin
				next_st.word_cnt = 10'h000;
				next_st.err_cnt = 10'h000;
			end else begin
				next_st.word_cnt = st.word_cnt + 10'h001;
				next_st.err_cnt = st.err_cnt + {9'h000, lvl[e1_rx_info_pkg::SRC_CRC_ERR]};
			end
		end
		// fas run of errored words; restarts after each trip
		if (pulse[e1_rx_info_pkg::SRC_FAS_WORD]) begin
			if (!lvl[e1_rx_info_pkg::SRC_FAS_ERR]) begin
				next_st.fas_run = 2'h0;
			end else if (st.fas_run == e1_rx_info_pkg::FAS_ERR_RUN - 2'h1) begin
				ev[e1_rx_info_pkg::FAS_RESYNC_BIT] = 1'b1; // RL7
				next_st.fas_run = 2'h0;
			end else begin
				next_st.fas_run = st.fas_run + 2'h1;
			end
		end
		// fas hunt restarting while crc resync runs means it locked to an emulator
		if (lvl[e1_rx_info_pkg::SRC_FAS_SEARCH] && !st.fas_search_prev
			&& lvl[e1_rx_info_pkg::SRC_CRC_SEARCH]) begin
			ev[e1_rx_info_pkg::FAS_RESYNC_BIT] = 1'b1; // RL8
		end
		next_st.fas_search_prev = lvl[e1_rx_info_pkg::SRC_FAS_SEARCH];
		// cas multiframe run of errored words
		if (pulse[e1_rx_info_pkg::SRC_CAS_WORD]) begin
			if (!lvl[e1_rx_info_pkg::SRC_CAS_ERR]) begin
				next_st.cas_run = 2'h0;
			end else if (st.cas_run == e1_rx_info_pkg::CAS_ERR_RUN - 2'h1) begin
				ev[e1_rx_info_pkg::CAS_RESYNC_BIT] = 1'b1; // RL9
				next_st.cas_run = 2'h0;
			end else begin
				next_st.cas_run = st.cas_run + 2'h1;
			end
		end
		// sync counter: clear has priority over a coincident timeout
		if (!lvl[e1_rx_info_pkg::SRC_CRC4_ENABLE] || pulse[e1_rx_info_pkg::SRC_CRC_LOCKED]) begin
			next_st.sync_count = e1_rx_info_pkg::SYNC_COUNT_RESET; // RL17
		end else if (pulse[e1_rx_info_pkg::SRC_CRC_TIMEOUT]) begin
			next_st.sync_count = st.sync_count + 6'h01; // RL17
		end
		// mask write: ones refresh the read copy and clear; a new event always wins
		if (wr_en && addr_hit(addr, e1_rx_info_pkg::FLAGS_OFFSET)) begin
			next_st.snap = (wr_data & st.flags) | (~wr_data & st.snap); // RL15
			next_st.flags = (st.flags & ~wr_data) | ev; // RL14
		end else begin
			next_st.flags = st.flags | ev; // RL14
		end
		// reads answer one cycle later; unmapped addresses read zero
		if (rd_en) begin
			next_st.rd_valid = 1'b1;
			if (addr_hit(addr, e1_rx_info_pkg::FLAGS_OFFSET)) begin
				next_st.rd_data = st.snap;
			end else if (addr_hit(addr, e1_rx_info_pkg::STATUS_OFFSET)) begin
				next_st.rd_data = live_status; // RL16
			end else begin
				next_st.rd_data = e1_rx_info_pkg::RDATA_RESET;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rd_data = st.rd_data;
	assign rd_valid = st.rd_valid;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	a_tx_full_set: assert property (pulse[e1_rx_info_pkg::SRC_TX_FULL] |=> st.flags[7]) // RL1
		else $error("tx full event not latched");
	a_tx_empty_set: assert property (pulse[e1_rx_info_pkg::SRC_TX_EMPTY] |=> st.flags[6]) // RL2
		else $error("tx empty event not latched");
	a_jit_limit_set: assert property (pulse[e1_rx_info_pkg::SRC_JIT_LIMIT] |=> st.flags[5]) // RL3
		else $error("jitter limit event not latched");
	a_rx_slip_set: assert property (pulse[e1_rx_info_pkg::SRC_RX_FULL] |=> st.flags[4]) // RL4
		else $error("rx full event not latched");
	a_rx_empty_set: assert property (pulse[e1_rx_info_pkg::SRC_RX_EMPTY] |=> st.flags[3]) // RL5
		else $error("rx empty event not latched");
	a_crc_window_trip: assert property (pulse[5] && lvl[6] && st.err_cnt == 10'h0392 |=> st.flags[2]) // RL6
		else $error("crc resync not flagged at 915 errors");
	a_crc_window_bound: assert property (st.word_cnt < 10'h03e8 && st.err_cnt <= st.word_cnt) // RL6
		else $error("crc window counters out of range");
	a_fas_run_trip: assert property (pulse[7] && lvl[8] && st.fas_run == 2'h2 // RL7
		|=> st.flags[1] && st.fas_run == 2'h0)
		else $error("fas resync not flagged on third error");
	a_fas_emulator_set: assert property ($rose(lvl[14]) && lvl[16] |=> st.flags[1]) // RL8
		else $error("fas re-search during crc resync not flagged");
	a_cas_run_trip: assert property (pulse[9] && lvl[10] && st.cas_run == 2'h1 |=> st.flags[0]) // RL9
		else $error("cas resync not flagged on second error");
	a_status_read_map: assert property (rd_en && addr == 8'h1e |=> rd_valid // RL10
		&& rd_data == {$past(st.sync_count[5:2]), $past(st.sync_count[0]),
		$past(lvl[14]), $past(lvl[15]), $past(lvl[16])})
		else $error("status read does not match live state");
	a_flag_sticky: assert property ((($past(st.flags) // RL14
		& ~(($past(wr_en) && $past(addr) == 8'h08) ? $past(wr_data) : 8'h00))
		& ~st.flags) == 8'h00)
		else $error("latched flag dropped without a mask write");
	a_mask_refresh: assert property (wr_en && addr == 8'h08 |=> st.snap == (($past(wr_data) & $past(st.flags))
		| (~$past(wr_data) & $past(st.snap)))) // RL15
		else $error("mask write refreshed wrong bits");
	a_count_step: assert property (pulse[11] && lvl[13] && !pulse[12] // RL17
		|=> st.sync_count == $past(st.sync_count) + 6'h01)
		else $error("sync counter did not step on timeout");
	a_count_clear: assert property (!lvl[13] |=> st.sync_count == 6'h00) // RL17
		else $error("sync counter not cleared with crc4 disabled");
endmodule // e1_rx_info_sync_status

// ---- dv/e1_host_model.sv ----
// host processor model for the parallel control port
`timescale 1ns/1ps
module e1_host_model (
	input wire logic clk_sys,
	output logic [7:0] addr,
	output logic wr_en,
	output logic [7:0] wr_data,
	output logic rd_en,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid
);
	initial begin
		addr = 8'h00;
		wr_en = 1'b0;
		wr_data = 8'h00;
		rd_en = 1'b0;
	end
	// one-cycle write strobe, changed only at falling edges
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		addr = a;
		wr_data = d;
		wr_en = 1'b1;
		@(negedge clk_sys);
		wr_en = 1'b0;
		addr = ~a; // a released bus shows no stale value
		wr_data = ~d;
	endtask
	// answer is taken in the cycle after the strobe edge, while rd_valid stands
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(negedge clk_sys);
		addr = a;
		rd_en = 1'b1;
		@(negedge clk_sys);
		rd_en = 1'b0;
		addr = ~a;
		d = rd_data;
		v = rd_valid;
	endtask
	// write-read-write: the write-back covers events that raced the read
	task automatic poll(input logic [7:0] m, output logic [7:0] d, output logic v);
		wr(e1_rx_info_pkg::FLAGS_OFFSET, m);
		rd(e1_rx_info_pkg::FLAGS_OFFSET, d, v);
		wr(e1_rx_info_pkg::FLAGS_OFFSET, d & m);
	endtask
endmodule // e1_host_model

// ---- dv/e1_rx_info_sync_status_bench.sv ----
// self-checking bench for the receive flags and synchronizer status registers
`timescale 1ns/1ps
`define chk(a, b) begin \
	n_tests++; \
	if ((a) !== (b)) begin \
		err_count++; \
		$display("Error %0t: got %h expected %h", $time, (a), (b)); \
	end \
end
module e1_rx_info_sync_status_bench;
	logic clk_sys, rst_b, wr_en, rd_en, rd_valid, crc_en, fas_sa, cas_sa, crc_sa;
	logic [7:0] addr, wr_data, rd_data;
	logic [6:0] ev; // toggles: slips, jitter, then 5 timeout, 6 lock
	logic [2:0] wtog, werr; // words: 0 crc, 1 fas, 2 cas
	int err_count, n_tests;
	e1_host_model u_host (.clk_sys(clk_sys), .addr(addr), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en),
		.rd_data(rd_data), .rd_valid(rd_valid));
	e1_rx_info_sync_status u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr), .wr_en(wr_en),
		.wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid),
		.tx_slip_buffer_full(ev[0]), .tx_slip_buffer_empty(ev[1]), .jitter_fifo_limit_trip(ev[2]),
		.rx_slip_buffer_full(ev[3]), .rx_slip_buffer_empty(ev[4]),
		.crc_word_toggle(wtog[0]), .crc_word_errored(werr[0]), .fas_word_toggle(wtog[1]),
		.fas_word_errored(werr[1]), .cas_word_toggle(wtog[2]), .cas_word_errored(werr[2]),
		.crc_search_timeout(ev[5]), .crc_sync_locked(ev[6]), .crc4_mode_enable(crc_en),
		.frame_align_search_active(fas_sa), .signaling_mf_search_active(cas_sa), .crc_mf_search_active(crc_sa));
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic pchk(input logic [7:0] m, input logic [7:0] exp);
		logic [7:0] d;
		logic v;
		u_host.poll(m, d, v);
		`chk(v, 1'b1)
		`chk(d, exp)
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic v;
		u_host.rd(a, d, v);
		`chk(v, 1'b1)
		`chk(d, exp)
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// gap of several cycles so that successive toggles never merge
	task automatic pulse(input int i);
		@(negedge clk_sys);
		ev[i] = ~ev[i];
		idle(5);
	endtask
	// errored level leads the toggle and is held past the synchroniser
	task automatic word(input int k, input logic e);
		@(negedge clk_sys);
		werr[k] = e;
		idle(1);
		wtog[k] = ~wtog[k];
		idle(4);
	endtask
	// hang guard
	initial begin
		repeat (50000) @(posedge clk_sys);
		err_count++;
		$display("Error %0t: run did not complete", $time);
		finish_test();
	end
	initial begin
		rst_b = 1'b0;
		ev = '0;
		wtog = '0;
		werr = '0;
		crc_en = 1'b1;
		fas_sa = 1'b0;
		cas_sa = 1'b0;
		crc_sa = 1'b0;
		err_count = 0;
		n_tests = 0;
		// three full cycles of reset, released off the sampling edge
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		rst_b = 1'b1;
		pchk(8'hff, 8'h00);
		u_host.wr(8'h1e, 8'hff);
		rchk(8'h1e, 8'h00);
		rchk(8'h55, 8'h00);
		// each event latches its own bit, then clears once polled
		for (int i = 0; i < 5; i++) begin
			pulse(i);
			pchk(8'hff, 8'h80 >> i);
			pchk(8'hff, 8'h00);
		end
		pulse(0);
		pulse(1);
		pchk(8'h40, 8'h40);
		pchk(8'h80, 8'h80);
		word(1, 1'b1);
		word(1, 1'b1);
		pchk(8'h02, 8'h00);
		word(1, 1'b1);
		pchk(8'h02, 8'h02);
		word(2, 1'b1);
		word(2, 1'b0);
		word(2, 1'b1);
		pchk(8'h01, 8'h00);
		word(2, 1'b1);
		pchk(8'h01, 8'h01);
		for (int n = 0; n < 999; n++) word(0, n >= 85);
		pchk(8'h04, 8'h00);
		word(0, 1'b1);
		pchk(8'h04, 8'h04);
		// frame search restarting during a crc search
		crc_sa = 1'b1;
		idle(4);
		fas_sa = 1'b1;
		idle(4);
		pchk(8'h02, 8'h02);
		rchk(8'h1e, 8'h05);
		cas_sa = 1'b1;
		crc_sa = 1'b0;
		idle(4);
		rchk(8'h1e, 8'h06);
		// counter bit 1 is hidden, so 3 shows as bit 3 only
		repeat (3) pulse(5);
		rchk(8'h1e, 8'h0e);
		pulse(5);
		rchk(8'h1e, 8'h16);
		pulse(6);
		rchk(8'h1e, 8'h06);
		repeat (63) pulse(5);
		rchk(8'h1e, 8'hfe);
		pulse(5);
		rchk(8'h1e, 8'h06);
		pulse(5);
		crc_en = 1'b0;
		idle(4);
		pulse(5);
		rchk(8'h1e, 8'h06);
		finish_test();
	end
endmodule // e1_rx_info_sync_status_bench
